/* logic/pcde_pkg.sv */
// Package for the Port C/D/E direction and data block.
// Assumes a plain register port with byte-wide registers at word-free offsets.
package pcde_pkg;

    localparam int PCDE_AW = 4;
    localparam logic [3:0] PCDE_OFS_E_DIR = 4'h3;
    localparam logic [3:0] PCDE_OFS_C_DATA = 4'h4;
    localparam logic [3:0] PCDE_OFS_D_DATA = 4'h5;
    // Port C direction has no printed offset; placed beside Port D direction.
    localparam logic [3:0] PCDE_OFS_C_DIR = 4'h6;
    localparam logic [3:0] PCDE_OFS_D_DIR = 4'h7;

    localparam logic [1:0] PCDE_RST_TWO = 2'h0;
    localparam logic [7:0] PCDE_RST_EIGHT = 8'h00;

    // Die link width selections.
    typedef enum logic [1:0] {
        PCDE_LINK_OFF = 2'b00,
        PCDE_LINK_W4 = 2'b01,
        PCDE_LINK_W8 = 2'b10
    } pcde_link_e;

    // Register state of the block.
    typedef struct packed {
        logic [1:0] e_dir;
        logic [1:0] c_data;
        logic [1:0] c_dir;
        logic [7:0] d_data;
        logic [7:0] d_dir;
        logic [7:0] rdata;
    } pcde_regs_s;

    // One port's pin drive group.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pcde_drive_s;

endpackage : pcde_pkg

/* logic/pcde_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module pcde_sync
    import pcde_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pcde_sync_s;

    pcde_sync_s st;
    pcde_sync_s next_st;

    always_comb
    begin
        next_st.meta = async_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;
endmodule : pcde_sync

/* logic/pcde_pinmux.sv */
// Pin ownership mux: selects register control or die link control per pin.
// Assumes the die link logic supplies its own drive values and enables.
`timescale 1ns/1ps
module pcde_pinmux
    import pcde_pkg::*;
#(
    parameter int W = 8
)
(
    // Ownership
    input wire logic [W-1:0] alt_own_i,
    // General purpose control
    input wire logic [W-1:0] gp_data_i,
    input wire logic [W-1:0] gp_dir_i,
    // Alternate function control
    input wire logic [W-1:0] alt_out_i,
    input wire logic [W-1:0] alt_oe_i,
    // Pin drive
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe_o
);
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (alt_own_i[i])
            begin
                pin_o[i] = alt_out_i[i];
                pin_oe_o[i] = alt_oe_i[i];
            end
            else
            begin
                pin_o[i] = gp_data_i[i] & gp_dir_i[i];
                pin_oe_o[i] = gp_dir_i[i];
            end
        end
    end
endmodule : pcde_pinmux

/* logic/pcde_port.sv */
// Port C and D direction and data registers and Port E direction register, with die link and oscillator muxing.
// Assumes software on the plain register port and pins arriving asynchronously.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module pcde_port
    import pcde_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [PCDE_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Mode controls
    input wire logic osc_en_i,
    input wire pcde_link_e link_mode_i,
    // Die link side
    input wire logic link_int_out_i,
    input wire logic link_int_oe_i,
    input wire logic link_clk_out_i,
    input wire logic link_clk_oe_i,
    input wire logic [7:0] link_dat_out_i,
    input wire logic [7:0] link_dat_oe_i,
    output logic link_int_in_o,
    output logic [7:0] link_dat_in_o,
    // Oscillator side
    output logic [1:0] osc_pin_o,
    // Port E pins
    input wire logic [1:0] pe_pin_i,
    output logic [1:0] pe_pin_o,
    output logic [1:0] pe_pin_oe_o,
    // Port C pins
    input wire logic [1:0] pc_pin_i,
    output logic [1:0] pc_pin_o,
    output logic [1:0] pc_pin_oe_o,
    // Port D pins
    input wire logic [7:0] pd_pin_i,
    output logic [7:0] pd_pin_o,
    output logic [7:0] pd_pin_oe_o
);
    pcde_regs_s st;
    pcde_regs_s next_st;
    logic [1:0] pc_sync;
    logic [7:0] pd_sync;
    logic [1:0] pc_own;
    logic [7:0] pd_own;
    logic [7:0] pc_out8;
    logic [7:0] pc_oe8;

    // Mixing register bits with the pin image only for inputs.
    function automatic logic [7:0] pcde_readback(input logic [7:0] data, input logic [7:0] dir,
                                                 input logic [7:0] pin);
        pcde_readback = (data & dir) | (pin & ~dir);
    endfunction : pcde_readback

    pcde_sync #(.W(2)) u_sync_c (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(pc_pin_i),
        .sync_o(pc_sync)
    );

    pcde_sync #(.W(8)) u_sync_d (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(pd_pin_i),
        .sync_o(pd_sync)
    );

    // Port C belongs to the link whenever the link runs in either width.
    assign pc_own = (link_mode_i != PCDE_LINK_OFF) ? 2'b11 : 2'b00;
    always_comb
    begin
        case (link_mode_i)
            PCDE_LINK_W8: pd_own = 8'hff;
            PCDE_LINK_W4: pd_own = 8'h0f;
            default: pd_own = 8'h00;
        endcase
    end

    always_comb
    begin
        next_st = st;
        if (wr_i)
        begin
            case (addr_i)
                PCDE_OFS_E_DIR: next_st.e_dir = wdata_i[1:0];
                PCDE_OFS_C_DATA: next_st.c_data = wdata_i[1:0];
                PCDE_OFS_D_DATA: next_st.d_data = wdata_i;
                PCDE_OFS_C_DIR: next_st.c_dir = wdata_i[1:0];
                PCDE_OFS_D_DIR: next_st.d_dir = wdata_i;
                default: ;
            endcase
        end
        next_st.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                PCDE_OFS_E_DIR: next_st.rdata = {6'h00, st.e_dir};
                PCDE_OFS_C_DATA: next_st.rdata = pcde_readback({6'h00, st.c_data}, {6'h00, st.c_dir},
                                                               {6'h00, pc_sync});
                PCDE_OFS_D_DATA: next_st.rdata = pcde_readback(st.d_data, st.d_dir, pd_sync);
                PCDE_OFS_C_DIR: next_st.rdata = {6'h00, st.c_dir};
                PCDE_OFS_D_DIR: next_st.rdata = st.d_dir;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st.e_dir <= PCDE_RST_TWO;
            st.c_data <= PCDE_RST_TWO;
            st.c_dir <= PCDE_RST_TWO;
            st.d_data <= PCDE_RST_EIGHT;
            st.d_dir <= PCDE_RST_EIGHT;
            st.rdata <= PCDE_RST_EIGHT;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;

    // Port E: oscillator takes the pins without touching the stored direction.
    always_comb
    begin
        if (osc_en_i)
        begin
            pe_pin_o = 2'b00;
            pe_pin_oe_o = 2'b00;
        end
        else
        begin
            pe_pin_o = 2'b00;
            pe_pin_oe_o = st.e_dir;
        end
    end
    // The oscillator sees the raw pads; a synchroniser would break its analog path.
    assign osc_pin_o = osc_en_i ? pe_pin_i : 2'b00;

    pcde_pinmux #(.W(8)) u_mux_c (
        .alt_own_i({6'h00, pc_own}),
        .gp_data_i({6'h00, st.c_data}),
        .gp_dir_i({6'h00, st.c_dir}),
        .alt_out_i({6'h00, link_int_out_i, link_clk_out_i}),
        .alt_oe_i({6'h00, link_int_oe_i, link_clk_oe_i}),
        .pin_o(pc_out8),
        .pin_oe_o(pc_oe8)
    );
    assign pc_pin_o = pc_out8[1:0];
    assign pc_pin_oe_o = pc_oe8[1:0];
    assign link_int_in_o = pc_sync[1];

    pcde_pinmux #(.W(8)) u_mux_d (
        .alt_own_i(pd_own),
        .gp_data_i(st.d_data),
        .gp_dir_i(st.d_dir),
        .alt_out_i(link_dat_out_i),
        .alt_oe_i(link_dat_oe_i),
        .pin_o(pd_pin_o),
        .pin_oe_o(pd_pin_oe_o)
    );
    assign link_dat_in_o = pd_sync & pd_own;

    // Assertions.
    property p_edir_oe;
        @(posedge clk_i) disable iff (srst_i) !osc_en_i |-> pe_pin_oe_o == st.e_dir;
    endproperty
    a_edir_oe: assert property (p_edir_oe) else $error("Port E enable differs from direction");

    property p_osc_keeps;
        @(posedge clk_i) disable iff (srst_i) (osc_en_i && !wr_i) |=> st.e_dir == $past(st.e_dir);
    endproperty
    a_osc_keeps: assert property (p_osc_keeps) else $error("Port E direction moved under oscillator");

    property p_c_link;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i != PCDE_LINK_OFF |-> pc_pin_oe_o == {link_int_oe_i, link_clk_oe_i};
    endproperty
    a_c_link: assert property (p_c_link) else $error("Port C not owned by die link");

    property p_w8;
        @(posedge clk_i) disable iff (srst_i) link_mode_i == PCDE_LINK_W8 |-> pd_pin_oe_o == link_dat_oe_i;
    endproperty
    a_w8: assert property (p_w8) else $error("Port D not fully owned in 8-bit mode");

    property p_w4;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i == PCDE_LINK_W4 |-> pd_pin_oe_o[7:4] == st.d_dir[7:4];
    endproperty
    a_w4: assert property (p_w4) else $error("Upper Port D not general purpose in 4-bit mode");

    property p_d_read;
        @(posedge clk_i) disable iff (srst_i)
            (rd_i && addr_i == PCDE_OFS_D_DATA && !wr_i) ##1 !$past(wr_i)
            |-> rdata_o == pcde_readback($past(st.d_data), $past(st.d_dir), $past(pd_sync));
    endproperty
    a_d_read: assert property (p_d_read) else $error("Port D readback wrong");

    property p_c_gp;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i == PCDE_LINK_OFF |-> pc_pin_oe_o == st.c_dir && (pc_pin_o & ~st.c_dir) == 2'b00;
    endproperty
    a_c_gp: assert property (p_c_gp) else $error("Port C general purpose drive wrong");

    property p_write;
        @(posedge clk_i) disable iff (srst_i) (wr_i && addr_i == PCDE_OFS_D_DIR) |=> st.d_dir == $past(wdata_i);
    endproperty
    a_write: assert property (p_write) else $error("Port D direction write lost");

    property p_drive;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i == PCDE_LINK_OFF |-> (pd_pin_o & st.d_dir) == (st.d_data & st.d_dir);
    endproperty
    a_drive: assert property (p_drive) else $error("Port D output not register value");

    property p_upper;
        @(posedge clk_i) disable iff (srst_i) (rd_i && addr_i == PCDE_OFS_E_DIR) |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_upper: assert property (p_upper) else $error("Port E upper bits not zero");

    property p_edir_write;
        @(posedge clk_i) disable iff (srst_i)
            (wr_i && addr_i == PCDE_OFS_E_DIR) |=> st.e_dir == $past(wdata_i[1:0]);
    endproperty
    a_edir_write: assert property (p_edir_write) else $error("Port E direction write lost");

    property p_osc_route;
        @(posedge clk_i) disable iff (srst_i) osc_en_i |-> pe_pin_oe_o == 2'b00 && osc_pin_o == pe_pin_i;
    endproperty
    a_osc_route: assert property (p_osc_route) else $error("Port E pins not handed to oscillator");

    property p_c_int;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i != PCDE_LINK_OFF |-> pc_pin_o[1] == link_int_out_i;
    endproperty
    a_c_int: assert property (p_c_int) else $error("Port C pin 1 not die link interrupt");

    property p_c_clk;
        @(posedge clk_i) disable iff (srst_i)
            link_mode_i != PCDE_LINK_OFF |-> pc_pin_o[0] == link_clk_out_i && pc_pin_oe_o[0] == link_clk_oe_i;
    endproperty
    a_c_clk: assert property (p_c_clk) else $error("Port C pin 0 not die link clock");

    property p_c_read;
        @(posedge clk_i) disable iff (srst_i) (rd_i && addr_i == PCDE_OFS_C_DATA)
            |=> rdata_o == {6'h00, ($past(st.c_data) & $past(st.c_dir)) | ($past(pc_sync) & ~$past(st.c_dir))};
    endproperty
    a_c_read: assert property (p_c_read) else $error("Port C readback wrong");

    property p_w8_out;
        @(posedge clk_i) disable iff (srst_i) link_mode_i == PCDE_LINK_W8 |-> pd_pin_o == link_dat_out_i;
    endproperty
    a_w8_out: assert property (p_w8_out) else $error("Port D drive not die link data in 8-bit mode");

    property p_w4_low;
        @(posedge clk_i) disable iff (srst_i) link_mode_i == PCDE_LINK_W4
            |-> pd_pin_oe_o[3:0] == link_dat_oe_i[3:0] && link_dat_in_o[7:4] == 4'h0;
    endproperty
    a_w4_low: assert property (p_w4_low) else $error("Lower Port D not die link in 4-bit mode");

    property p_d_gp;
        @(posedge clk_i) disable iff (srst_i) link_mode_i == PCDE_LINK_OFF |-> pd_pin_oe_o == st.d_dir;
    endproperty
    a_d_gp: assert property (p_d_gp) else $error("Port D enable differs from direction");

    property p_c_dir_keep;
        @(posedge clk_i) disable iff (srst_i)
            (link_mode_i != PCDE_LINK_OFF && !wr_i) |=> st.c_dir == $past(st.c_dir);
    endproperty
    a_c_dir_keep: assert property (p_c_dir_keep) else $error("Port C direction moved under die link");

    property p_c_drive;
        @(posedge clk_i) disable iff (srst_i) link_mode_i == PCDE_LINK_OFF |-> pc_pin_o == (st.c_data & st.c_dir);
    endproperty
    a_c_drive: assert property (p_c_drive) else $error("Port C output not register value");

    // Reset is checked without a disable so that the cycle after every reset edge is seen.
    property p_reset;
        @(posedge clk_i) srst_i |=> st.e_dir == PCDE_RST_TWO && st.c_data == PCDE_RST_TWO
            && st.c_dir == PCDE_RST_TWO && st.d_data == PCDE_RST_EIGHT && st.d_dir == PCDE_RST_EIGHT
            && rdata_o == PCDE_RST_EIGHT;
    endproperty
    a_reset: assert property (p_reset) else $error("Register not cleared by reset");

    c_w8: cover property (@(posedge clk_i) link_mode_i == PCDE_LINK_W8);
    c_w4: cover property (@(posedge clk_i) link_mode_i == PCDE_LINK_W4 && st.d_dir[7:4] != 4'h0);
    c_osc: cover property (@(posedge clk_i) osc_en_i && st.e_dir != 2'b00);
    c_rd: cover property (@(posedge clk_i) rd_i && addr_i == PCDE_OFS_C_DATA);
endmodule : pcde_port

/* sim/pcde_pin_model.sv */
// Board side of the Port C, D and E pins: resolves each pin from the block's enable.
// Assumes the testbench sets what the board drives on pins the block leaves released.
`timescale 1ns/1ps
module pcde_pin_model
    import pcde_pkg::*;
(
    // Block drive
    input wire logic [1:0] pe_o_i,
    input wire logic [1:0] pe_oe_i,
    input wire logic [1:0] pc_o_i,
    input wire logic [1:0] pc_oe_i,
    input wire logic [7:0] pd_o_i,
    input wire logic [7:0] pd_oe_i,
    // Board drive
    input wire logic [1:0] pe_ext_i,
    input wire logic [1:0] pc_ext_i,
    input wire logic [7:0] pd_ext_i,
    // Pin levels
    output logic [1:0] pe_o,
    output logic [1:0] pc_o,
    output logic [7:0] pd_o
);
    // The board yields every pin the block drives, so no pin is ever contended.
    assign pe_o = (pe_oe_i & pe_o_i) | (~pe_oe_i & pe_ext_i);
    assign pc_o = (pc_oe_i & pc_o_i) | (~pc_oe_i & pc_ext_i);
    assign pd_o = (pd_oe_i & pd_o_i) | (~pd_oe_i & pd_ext_i);
endmodule : pcde_pin_model

/* sim/tb_pcde_port.sv */
// Self-checking bench for the port block with a board pin model.
// Assumes a 250 MHz clock and the register offsets of the package.
`timescale 1ns/1ps
module tb_pcde_port
    import pcde_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [PCDE_AW-1:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic osc_en_i = 1'b0;
    pcde_link_e link_mode_i = PCDE_LINK_OFF;
    logic link_int_out_i = 1'b0;
    logic link_int_oe_i = 1'b0;
    logic link_clk_out_i = 1'b0;
    logic link_clk_oe_i = 1'b0;
    logic [7:0] link_dat_out_i = 8'h00;
    logic [7:0] link_dat_oe_i = 8'h00;
    logic link_int_in_o;
    logic [7:0] link_dat_in_o;
    logic [1:0] osc_pin_o;
    logic [1:0] pe_pin_i, pe_pin_o, pe_pin_oe_o, pc_pin_i, pc_pin_o, pc_pin_oe_o;
    logic [7:0] pd_pin_i, pd_pin_o, pd_pin_oe_o;
    logic [1:0] pe_ext = 2'h2;
    logic [1:0] pc_ext = 2'h0;
    logic [7:0] pd_ext = 8'h0f;
    logic [7:0] d;
    int n_mismatch = 0;
    int check_count = 0;

    always #2 clk_i = ~clk_i;

    pcde_port uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .osc_en_i(osc_en_i), .link_mode_i(link_mode_i),
        .link_int_out_i(link_int_out_i), .link_int_oe_i(link_int_oe_i), .link_clk_out_i(link_clk_out_i),
        .link_clk_oe_i(link_clk_oe_i), .link_dat_out_i(link_dat_out_i), .link_dat_oe_i(link_dat_oe_i),
        .link_int_in_o(link_int_in_o), .link_dat_in_o(link_dat_in_o), .osc_pin_o(osc_pin_o),
        .pe_pin_i(pe_pin_i), .pe_pin_o(pe_pin_o), .pe_pin_oe_o(pe_pin_oe_o), .pc_pin_i(pc_pin_i),
        .pc_pin_o(pc_pin_o), .pc_pin_oe_o(pc_pin_oe_o), .pd_pin_i(pd_pin_i), .pd_pin_o(pd_pin_o),
        .pd_pin_oe_o(pd_pin_oe_o));

    pcde_pin_model board (.pe_o_i(pe_pin_o), .pe_oe_i(pe_pin_oe_o), .pc_o_i(pc_pin_o),
        .pc_oe_i(pc_pin_oe_o), .pd_o_i(pd_pin_o), .pd_oe_i(pd_pin_oe_o), .pe_ext_i(pe_ext),
        .pc_ext_i(pc_ext), .pd_ext_i(pd_ext), .pe_o(pe_pin_i), .pc_o(pc_pin_i), .pd_o(pd_pin_i));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Each strobe is one cycle wide; the task returns just after the edge that took the write.
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        rd_i <= 1'b0;
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : bus_rd

    task automatic bus_idle();
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : bus_idle

    // Data registers of released pins read back what the board drives.
    task automatic t_reset();
        logic [3:0] a;
        logic [7:0] want;
        for (int i = 0; i < 8; i++)
        begin
            a = 4'(i);
            want = 8'h00;
            if (a == PCDE_OFS_C_DATA)
                want = {6'h00, pc_ext};
            if (a == PCDE_OFS_D_DATA)
                want = pd_ext;
            bus_rd(a, d);
            chk("reset read", d, want);
        end
    endtask : t_reset

    task automatic t_port_e();
        bus_wr(PCDE_OFS_E_DIR, 8'hff);
        bus_rd(PCDE_OFS_E_DIR, d);
        chk("e dir", d, 8'h03);
        chk("e oe", {6'h0, pe_pin_oe_o}, 8'h03);
        chk("e out", {6'h0, pe_pin_o}, 8'h00);
        @(posedge clk_i);
        osc_en_i <= 1'b1;
        #1;
        chk("e oe osc", {6'h0, pe_pin_oe_o}, 8'h00);
        chk("osc pins", {6'h0, osc_pin_o}, 8'h02);
        bus_rd(PCDE_OFS_E_DIR, d);
        chk("e dir osc", d, 8'h03);
        @(posedge clk_i);
        osc_en_i <= 1'b0;
        bus_wr(PCDE_OFS_E_DIR, 8'h01);
        bus_idle();
        chk("e oe one", {6'h0, pe_pin_oe_o}, 8'h01);
    endtask : t_port_e

    task automatic t_port_c();
        bus_wr(PCDE_OFS_C_DIR, 8'h01);
        bus_wr(PCDE_OFS_C_DATA, 8'h03);
        bus_idle();
        chk("c oe", {6'h0, pc_pin_oe_o}, 8'h01);
        chk("c out", {7'h0, pc_pin_o[0]}, 8'h01);
        bus_wr(PCDE_OFS_C_DATA, 8'h02);
        bus_idle();
        repeat (3) @(posedge clk_i);
        bus_rd(PCDE_OFS_C_DATA, d);
        chk("c read", d, 8'h00);
    endtask : t_port_c

    task automatic t_port_d();
        bus_wr(PCDE_OFS_D_DIR, 8'h30);
        bus_wr(PCDE_OFS_D_DATA, 8'h5a);
        bus_rd(PCDE_OFS_D_DATA, d);
        repeat (3) @(posedge clk_i);
        bus_rd(PCDE_OFS_D_DATA, d);
        chk("d read", d, 8'h1f);
        chk("d oe", pd_pin_oe_o, 8'h30);
    endtask : t_port_d

    task automatic t_link();
        @(posedge clk_i);
        link_mode_i <= PCDE_LINK_W4;
        link_int_oe_i <= 1'b1;
        link_int_out_i <= 1'b1;
        link_dat_oe_i <= 8'hff;
        link_dat_out_i <= 8'ha5;
        repeat (4) @(posedge clk_i);
        #1;
        chk("c oe link", {6'h0, pc_pin_oe_o}, 8'h02);
        chk("int in", {7'h0, link_int_in_o}, 8'h01);
        chk("d oe w4", pd_pin_oe_o, 8'h3f);
        chk("d out w4", pd_pin_o & 8'h3f, 8'h15);
        chk("dat in w4", link_dat_in_o, 8'h05);
        bus_rd(PCDE_OFS_C_DIR, d);
        chk("c dir link", d, 8'h01);
        @(posedge clk_i);
        link_int_oe_i <= 1'b0;
        link_clk_oe_i <= 1'b1;
        link_clk_out_i <= 1'b1;
        link_mode_i <= PCDE_LINK_W8;
        #1;
        @(posedge clk_i);
        #1;
        chk("clk line", {5'h0, pc_pin_oe_o, pc_pin_o[0]}, 8'h03);
        chk("d oe w8", pd_pin_oe_o, 8'hff);
        chk("d out w8", pd_pin_o, 8'ha5);
    endtask : t_link

    // A reset in mid-run must clear every register written so far.
    task automatic t_rerun();
        @(posedge clk_i);
        link_mode_i <= PCDE_LINK_OFF;
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk("d oe rst", pd_pin_oe_o, 8'h00);
        chk("c oe rst", {6'h0, pc_pin_oe_o}, 8'h00);
        t_reset();
    endtask : t_rerun

    initial
    begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_port_e();
        t_port_c();
        t_port_d();
        t_link();
        t_rerun();
        finish_test();
    end

    // The scenarios need well under a thousand cycles.
    initial
    begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule : tb_pcde_port
